// ===== verilog/pcm_pkg.sv
// Purpose: Constants for the power clock manager register block.
// Assumes: AXI4-Lite slave, 32-bit words, source clocks arrive as tick pulses.
// Notes: All offsets are byte addresses inside a 128-byte window.
//
// How it works
// - Three programmable outputs, set/clear by enable/disable writes, shown in status.
// - Programmable outputs stay off after reset until software enables them.
// - Each output picks main, slow or PLL clock; slow after reset.
// - Output equals source divided by 1,2,4,8,16,32 or 64; reset divides by 1.
// - Ready flag sets on an enabled output's first pulse after a setup write, or on an old-setting pulse in that write's own cycle.
// - A set ready flag with its interrupt enabled raises the interrupt line.
// - Source and divider fields are taken together in one register write.
// - Per-peripheral gates set/cleared by enable/disable writes, shown in status.
// - Every enabled peripheral clock is a gated copy of the master clock.
// - Active master prescaler adds at most 64 new-clock cycles to a switch.
// - PLL-to-main switch ends within 3 PLL, 4 slow and 1 main periods.
// - System clock status reads 0x01 after reset.
// - Writing one to bit 7 enables the USB port clock; zero changes nothing.
// - Programmable outputs 0, 1, 2 sit in bits 8, 9, 10.
// - Disabled peripheral clocks stop at once; all are off after reset.
// - No glitch guard on the output path; reconfigure while disabled.

package pcm_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned NUM_OUT = 3;

  // Register byte offsets
  localparam logic [6:0] OFS_SYS_EN = 7'h00;
  localparam logic [6:0] OFS_SYS_DIS = 7'h04;
  localparam logic [6:0] OFS_SYS_STATE = 7'h08;
  localparam logic [6:0] OFS_PER_EN = 7'h10;
  localparam logic [6:0] OFS_PER_DIS = 7'h14;
  localparam logic [6:0] OFS_PER_STATE = 7'h18;
  localparam logic [6:0] OFS_OSC_CTRL = 7'h20;
  localparam logic [6:0] OFS_FREQ_MEAS = 7'h24;
  localparam logic [6:0] OFS_PLL_SETUP = 7'h2C;
  localparam logic [6:0] OFS_MCK_SETUP = 7'h30;
  localparam logic [6:0] OFS_OUT0_SETUP = 7'h40;
  localparam logic [6:0] OFS_OUT1_SETUP = 7'h44;
  localparam logic [6:0] OFS_OUT2_SETUP = 7'h48;
  localparam logic [6:0] OFS_IRQ_SET = 7'h60;
  localparam logic [6:0] OFS_IRQ_CLR = 7'h64;
  localparam logic [6:0] OFS_FLAGS = 7'h68;
  localparam logic [6:0] OFS_IRQ_VIEW = 7'h6C;

  // System clock register bits
  localparam int unsigned SYS_PROC_BIT = 0;
  localparam int unsigned SYS_USB_BIT = 7;
  localparam int unsigned SYS_OUT_LSB = 8;

  // Setup register fields (master and programmable outputs alike)
  localparam int unsigned FLD_SRC_LSB = 0;
  localparam int unsigned FLD_DIV_LSB = 2;
  localparam int unsigned SETUP_W = 5;
  localparam logic [2:0] DIV_CODE_MAX = 3'h6;

  // Source select codes; code 2 is reserved and falls back to slow clock
  localparam logic [1:0] SRC_SLOW = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h3;

  // Manager flag bits
  localparam int unsigned FLAG_MCK_RDY_BIT = 3;
  localparam int unsigned FLAG_OUT_LSB = 8;
  localparam logic [31:0] FLAG_MASK = 32'h0000_0708;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_PLL_SETUP = 32'h0000_3F00;
  localparam logic [4:0] RST_SETUP = 5'h00;

  // Master switch: slow clock edges waited while crossing sources
  localparam logic [1:0] SW_SLOW_TICKS = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pcm_pkg

// ===== verilog/pcm_top.sv
// Purpose: Clock gating and programmable clock outputs of a power manager.
// Assumes: Source clocks come as one-cycle tick pulses synchronous to clk.
// Notes: Every generated clock but the USB port clock (a level enable) leaves as a one-cycle enable pulse.
//
// Our own choice: the AXI4-Lite interface to the registers.

`timescale 1ns/100ps
`default_nettype none

module pcm_top #(
  parameter logic [31:0] PER_IMPL = 32'h0000_FFFC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pcm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slow_clock_tick,
  input wire logic main_clock_tick,
  input wire logic pll_clock_tick,
  output logic [2:0] prog_clock_output,
  output logic master_clock_tick,
  output logic proc_clock_tick,
  output logic usb_port_clock_on,
  output logic [31:0] periph_clock_tick,
  output logic irq
);

  typedef enum logic [4:0] {
    PCM_SW_IDLE = 5'b00001,
    PCM_SW_OLD = 5'b00010,
    PCM_SW_SLOW = 5'b00100,
    PCM_SW_NEW = 5'b01000,
    PCM_SW_DIVIDER_FIELD = 5'b10000
  } pcm_sw_e;

  typedef struct packed {
    logic aw_held;
    logic [pcm_pkg::ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic proc_on;
    logic usb_on;
    logic [2:0] out_on;
    logic [31:0] per_on;
    logic [31:0] osc_ctrl;
    logic [31:0] pll_setup;
    logic [4:0] mck_setup;
    logic [2:0][4:0] out_setup;
    logic [31:0] irq_mask;
    logic [2:0][5:0] out_cnt;
    logic [2:0] out_rdy;
    logic [2:0] out_pulse;
    logic [1:0] mck_src;
    logic [2:0] mck_div;
    pcm_sw_e sw;
    logic [1:0] sw_slow;
    logic [5:0] mck_cnt;
    logic mck_rdy;
    logic mck_pulse;
    logic proc_pulse;
    logic [31:0] per_pulse;
    logic irq;
  } pcm_state_s;

  pcm_state_s s_ff;
  pcm_state_s nxt_s;

  // Tick of the selected source; the reserved code behaves as slow clock
  function automatic logic src_tick(input logic [1:0] sel, input logic slow,
                                    input logic main, input logic pll);
    return (sel == pcm_pkg::SRC_MAIN) ? main :
           (sel == pcm_pkg::SRC_PLL) ? pll : slow;
  endfunction

  // True when this source tick closes a period of 2**code ticks; code 7 counts as 6 (64 ticks)
  function automatic logic div_hit(input logic [5:0] cnt,
                                   input logic [2:0] code);
    logic [2:0] k;
    logic [6:0] span;
    logic [5:0] mask;
    k = (code > pcm_pkg::DIV_CODE_MAX) ? pcm_pkg::DIV_CODE_MAX : code;
    span = 7'h01 << k;
    mask = 6'(span - 7'h01);
    return (cnt & mask) == mask;
  endfunction

  // Byte-lane merge for read-write registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Flag word built from the live ready bits
  function automatic logic [31:0] flags_of(input pcm_state_s st);
    logic [31:0] f;
    f = pcm_pkg::RST_ZERO;
    f[pcm_pkg::FLAG_MCK_RDY_BIT] = st.mck_rdy;
    f[pcm_pkg::FLAG_OUT_LSB +: pcm_pkg::NUM_OUT] = st.out_rdy;
    return f;
  endfunction

  // Register read decode; reserved bits read zero
  function automatic logic [32:0] read_reg(input pcm_state_s st,
                                           input logic [6:0] a);
    logic [31:0] d;
    logic err;
    d = pcm_pkg::RST_ZERO;
    err = 1'b0;
    unique case ({a[6:2], 2'b00})
      pcm_pkg::OFS_SYS_EN, pcm_pkg::OFS_SYS_DIS, pcm_pkg::OFS_PER_EN,
      pcm_pkg::OFS_PER_DIS, pcm_pkg::OFS_IRQ_SET,
      pcm_pkg::OFS_IRQ_CLR: d = pcm_pkg::RST_ZERO;
      pcm_pkg::OFS_SYS_STATE: begin
        d[pcm_pkg::SYS_PROC_BIT] = st.proc_on;
        d[pcm_pkg::SYS_USB_BIT] = st.usb_on;
        d[pcm_pkg::SYS_OUT_LSB +: pcm_pkg::NUM_OUT] = st.out_on;
      end
      pcm_pkg::OFS_PER_STATE: d = st.per_on;
      pcm_pkg::OFS_OSC_CTRL: d = st.osc_ctrl;
      pcm_pkg::OFS_FREQ_MEAS: d = pcm_pkg::RST_ZERO;
      pcm_pkg::OFS_PLL_SETUP: d = st.pll_setup;
      pcm_pkg::OFS_MCK_SETUP: d[4:0] = st.mck_setup;
      pcm_pkg::OFS_OUT0_SETUP: d[4:0] = st.out_setup[0];
      pcm_pkg::OFS_OUT1_SETUP: d[4:0] = st.out_setup[1];
      pcm_pkg::OFS_OUT2_SETUP: d[4:0] = st.out_setup[2];
      pcm_pkg::OFS_FLAGS: d = flags_of(st);
      pcm_pkg::OFS_IRQ_VIEW: d = st.irq_mask;
      default: err = 1'b1;
    endcase
    return {err, d};
  endfunction

  // Next state: bus slave, register writes, dividers and master switch
  always_comb begin
    logic [31:0] wm;
    logic [6:0] wa;
    logic wr_go;
    logic wr_err;
    logic [32:0] rd;
    logic [2:0] cfg_wr;
    logic [2:0] tick;
    logic [2:0] hit;
    logic mtick;
    logic mhit;
    logic done;
    logic [1:0] tgt_src;
    wm = pcm_pkg::RST_ZERO;
    wa = s_ff.aw_addr;
    wr_go = 1'b0;
    wr_err = 1'b0;
    rd = {1'b0, pcm_pkg::RST_ZERO};
    cfg_wr = 3'b000;
    tick = 3'b000;
    hit = 3'b000;
    mtick = 1'b0;
    mhit = 1'b0;
    done = 1'b0;
    tgt_src = s_ff.mck_setup[pcm_pkg::FLD_SRC_LSB +: 2];
    nxt_s = s_ff;

    // Write channel: address and data held independently, any order
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.awready && s_axi_awvalid) begin
      nxt_s.aw_held = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr;
    end
    if (s_ff.wready && s_axi_wvalid) begin
      nxt_s.w_held = 1'b1;
      nxt_s.w_data = s_axi_wdata;
      nxt_s.w_strb = s_axi_wstrb;
    end
    // A write executes only once the previous response has gone
    if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid) begin
      wr_go = 1'b1;
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held = 1'b0;
      nxt_s.bvalid = 1'b1;
      wm = merge(pcm_pkg::RST_ZERO, s_ff.w_data, s_ff.w_strb);
    end

    if (wr_go) begin
      unique case ({wa[6:2], 2'b00})
        pcm_pkg::OFS_SYS_EN: begin
          nxt_s.proc_on = s_ff.proc_on | wm[pcm_pkg::SYS_PROC_BIT];
          nxt_s.usb_on = s_ff.usb_on | wm[pcm_pkg::SYS_USB_BIT];
          nxt_s.out_on = s_ff.out_on |
                         wm[pcm_pkg::SYS_OUT_LSB +: pcm_pkg::NUM_OUT];
        end
        pcm_pkg::OFS_SYS_DIS: begin
          nxt_s.proc_on = s_ff.proc_on & ~wm[pcm_pkg::SYS_PROC_BIT];
          nxt_s.usb_on = s_ff.usb_on & ~wm[pcm_pkg::SYS_USB_BIT];
          nxt_s.out_on = s_ff.out_on &
                         ~wm[pcm_pkg::SYS_OUT_LSB +: pcm_pkg::NUM_OUT];
        end
        pcm_pkg::OFS_PER_EN: begin
          nxt_s.per_on = s_ff.per_on | (wm & PER_IMPL);
        end
        pcm_pkg::OFS_PER_DIS: begin
          nxt_s.per_on = s_ff.per_on & ~(wm & PER_IMPL);
        end
        pcm_pkg::OFS_OSC_CTRL: begin
          nxt_s.osc_ctrl = merge(s_ff.osc_ctrl, s_ff.w_data, s_ff.w_strb);
        end
        pcm_pkg::OFS_PLL_SETUP: begin
          nxt_s.pll_setup = merge(s_ff.pll_setup, s_ff.w_data,
                                  s_ff.w_strb);
        end
        pcm_pkg::OFS_MCK_SETUP: begin
          nxt_s.mck_setup = s_ff.w_strb[0] ? s_ff.w_data[4:0] :
                            s_ff.mck_setup;
        end
        pcm_pkg::OFS_OUT0_SETUP, pcm_pkg::OFS_OUT1_SETUP,
        pcm_pkg::OFS_OUT2_SETUP: begin
          // Source and divider land together in one write
          for (int i = 0; i < pcm_pkg::NUM_OUT; i++) begin
            if (wa[3:2] == 2'(i)) begin
              nxt_s.out_setup[i] = s_ff.w_strb[0] ? s_ff.w_data[4:0] :
                                   s_ff.out_setup[i];
              cfg_wr[i] = 1'b1;
            end
          end
        end
        pcm_pkg::OFS_IRQ_SET: begin
          nxt_s.irq_mask = s_ff.irq_mask | (wm & pcm_pkg::FLAG_MASK);
        end
        pcm_pkg::OFS_IRQ_CLR: begin
          nxt_s.irq_mask = s_ff.irq_mask & ~wm;
        end
        pcm_pkg::OFS_SYS_STATE, pcm_pkg::OFS_PER_STATE,
        pcm_pkg::OFS_FREQ_MEAS, pcm_pkg::OFS_FLAGS,
        pcm_pkg::OFS_IRQ_VIEW: wr_err = 1'b0; // Read-only, answered OKAY
        default: wr_err = 1'b1;
      endcase
      nxt_s.bresp = wr_err ? pcm_pkg::RESP_SLVERR : pcm_pkg::RESP_OKAY;
    end
    nxt_s.awready = !nxt_s.aw_held;
    nxt_s.wready = !nxt_s.w_held;

    // Read channel: one outstanding read, data one cycle after address
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_ff.arready && s_axi_arvalid) begin
      rd = read_reg(s_ff, s_axi_araddr);
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd[31:0];
      nxt_s.rresp = rd[32] ? pcm_pkg::RESP_SLVERR : pcm_pkg::RESP_OKAY;
    end
    nxt_s.arready = !nxt_s.rvalid;

    // Programmable outputs; no glitch guard on a live reconfiguration
    for (int i = 0; i < pcm_pkg::NUM_OUT; i++) begin
      tick[i] = src_tick(s_ff.out_setup[i][pcm_pkg::FLD_SRC_LSB +: 2],
                         slow_clock_tick, main_clock_tick,
                         pll_clock_tick);
      hit[i] = s_ff.out_on[i] && tick[i] &&
               div_hit(s_ff.out_cnt[i],
                       s_ff.out_setup[i][pcm_pkg::FLD_DIV_LSB +: 3]);
      if (!nxt_s.out_on[i] || cfg_wr[i]) begin
        nxt_s.out_cnt[i] = 6'h00;
      end else if (tick[i]) begin
        nxt_s.out_cnt[i] = s_ff.out_cnt[i] + 6'h01;
      end
      nxt_s.out_pulse[i] = hit[i];
      // Set wins over disable or reconfiguration in the same cycle
      nxt_s.out_rdy[i] = hit[i] |
        (s_ff.out_rdy[i] & nxt_s.out_on[i] & ~cfg_wr[i]);
    end

    // Master clock divider on the current source
    mtick = src_tick(s_ff.mck_src, slow_clock_tick, main_clock_tick,
                     pll_clock_tick);
    mhit = mtick && div_hit(s_ff.mck_cnt, s_ff.mck_div);
    if (mtick) begin
      nxt_s.mck_cnt = s_ff.mck_cnt + 6'h01;
    end

    // Master switch: old edge, two slow edges, new edge, prescaler wrap
    unique case (s_ff.sw)
      PCM_SW_IDLE: begin
        if (s_ff.mck_setup != {s_ff.mck_div, s_ff.mck_src}) begin
          nxt_s.sw = PCM_SW_OLD;
        end
      end
      PCM_SW_OLD: begin
        if (mtick) begin
          nxt_s.sw = PCM_SW_SLOW;
          nxt_s.sw_slow = 2'h0;
        end
      end
      PCM_SW_SLOW: begin
        if (slow_clock_tick) begin
          nxt_s.sw_slow = s_ff.sw_slow + 2'h1;
          if (s_ff.sw_slow + 2'h1 == pcm_pkg::SW_SLOW_TICKS) begin
            nxt_s.sw = PCM_SW_NEW;
          end
        end
      end
      PCM_SW_NEW: begin
        if (src_tick(tgt_src, slow_clock_tick, main_clock_tick,
                     pll_clock_tick)) begin
          nxt_s.mck_src = tgt_src;
          nxt_s.mck_div = s_ff.mck_setup[pcm_pkg::FLD_DIV_LSB +: 3];
          nxt_s.mck_cnt = 6'h00;
          nxt_s.sw = PCM_SW_DIVIDER_FIELD;
        end
      end
      PCM_SW_DIVIDER_FIELD: begin
        if (s_ff.mck_div == 3'h0 || mhit) begin
          done = 1'b1;
          nxt_s.sw = PCM_SW_IDLE;
        end
      end
      default: nxt_s.sw = PCM_SW_IDLE;
    endcase
    nxt_s.mck_rdy = done | (s_ff.mck_rdy & (s_ff.sw == PCM_SW_IDLE) &
      (s_ff.mck_setup == {s_ff.mck_div, s_ff.mck_src}));

    // Gated copies of the master clock; a disable removes the next pulse
    nxt_s.mck_pulse = mhit;
    nxt_s.proc_pulse = mhit & nxt_s.proc_on;
    nxt_s.per_pulse = nxt_s.per_on & {32{mhit}};

    // Interrupt level from masked flags
    nxt_s.irq = |(flags_of(nxt_s) & nxt_s.irq_mask);
  end

  // State register; reset gives slow source, divide by one, all gates off but the processor clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '{
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        proc_on: 1'b1,
        pll_setup: pcm_pkg::RST_PLL_SETUP,
        mck_src: pcm_pkg::SRC_SLOW,
        sw: PCM_SW_IDLE,
        mck_rdy: 1'b1,
        // Gates, outputs, masks and setups clear: slow source, divide by 1
        default: '0
      };
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign prog_clock_output = s_ff.out_pulse;
  assign master_clock_tick = s_ff.mck_pulse;
  assign proc_clock_tick = s_ff.proc_pulse;
  assign usb_port_clock_on = s_ff.usb_on;
  assign periph_clock_tick = s_ff.per_pulse;
  assign irq = s_ff.irq;

endmodule // pcm_top

`default_nettype wire

// ===== test/pcm_top_sva.sv
// Purpose: Port-level checks for the power clock manager.
// Assumes: Single clock domain, async active-low reset.
// Notes: Sees only top ports; bound at the foot of this file.
`timescale 1ns/100ps
`default_nettype none

module pcm_top_sva #(
  parameter logic [31:0] PER_IMPL = 32'h0000_FFFC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic slow_clock_tick,
  input wire logic main_clock_tick,
  input wire logic pll_clock_tick,
  input wire logic [2:0] prog_clock_output,
  input wire logic master_clock_tick,
  input wire logic proc_clock_tick,
  input wire logic usb_port_clock_on,
  input wire logic [31:0] periph_clock_tick,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // No programmable output, interrupt or USB clock may come out of reset already running
  property p_rst_quiet;
    $rose(rst_n) |-> prog_clock_output == 3'h0 && !irq && !usb_port_clock_on;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("output active right after reset");
  // A divided pulse always follows a source tick by one edge
  property p_prog_src;
    prog_clock_output != 3'h0 |->
      $past(slow_clock_tick || main_clock_tick || pll_clock_tick);
  endproperty
  a_prog_src: assert property (p_prog_src)
    else $error("programmable pulse without source tick");
  property p_per_gate;
    periph_clock_tick != 32'h0 |-> master_clock_tick;
  endproperty
  a_per_gate: assert property (p_per_gate)
    else $error("peripheral pulse without master pulse");
  property p_proc_gate;
    proc_clock_tick |-> master_clock_tick;
  endproperty
  a_proc_gate: assert property (p_proc_gate)
    else $error("processor pulse without master pulse");
  // Absent peripherals must never receive a clock
  property p_per_impl;
    (periph_clock_tick & ~PER_IMPL) == 32'h0;
  endproperty
  a_per_impl: assert property (p_per_impl)
    else $error("clock on unimplemented peripheral");
  // The USB enable only moves when a write completes
  property p_usb_on_write;
    $changed(usb_port_clock_on) |-> $rose(s_axi_bvalid);
  endproperty
  a_usb_on_write: assert property (p_usb_on_write)
    else $error("usb clock changed outside a write");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_w_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      !s_axi_bvalid |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w_resp: assert property (p_w_resp)
    else $error("write response late");
  property p_r_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_resp: assert property (p_r_resp)
    else $error("read response late");

  c_prog: cover property (prog_clock_output != 3'h0);
  c_irq: cover property ($rose(irq));
  c_per: cover property (periph_clock_tick != 32'h0);
endmodule // pcm_top_sva

bind pcm_top pcm_top_sva #(.PER_IMPL(PER_IMPL)) u_sva (.clk(clk),
  .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .slow_clock_tick(slow_clock_tick),
  .main_clock_tick(main_clock_tick), .pll_clock_tick(pll_clock_tick),
  .prog_clock_output(prog_clock_output),
  .master_clock_tick(master_clock_tick), .proc_clock_tick(proc_clock_tick),
  .usb_port_clock_on(usb_port_clock_on),
  .periph_clock_tick(periph_clock_tick), .irq(irq));
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: Register-level tests of the power clock manager.
// Assumes: Bench drives AXI4-Lite and source ticks at the rising edge.
// Notes: Handshakes are sampled at the falling edge, acted on at the next rise.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] awaddr = 7'h00, araddr = 7'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, master, proc, usb, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, per_tick;
  logic [2:0] prog;
  logic slow = 1'b0, main = 1'b0, pll = 1'b0;
  logic [31:0] cyc = 32'h0000_0000, rd, exp_rd[6];
  logic [6:0] rst_adr[6];
  logic [1:0] resp;
  int mismatches = 0, samples_checked = 0, g, n4, n8;

  pcm_top uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .slow_clock_tick(slow), .main_clock_tick(main),
    .pll_clock_tick(pll), .prog_clock_output(prog), .master_clock_tick(master),
    .proc_clock_tick(proc), .usb_port_clock_on(usb),
    .periph_clock_tick(per_tick), .irq(irq));

  always #20 clk = ~clk;

  // Sources: slow every 8 cycles, main every 2, PLL every 3
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    slow <= (cyc % 8) == 7;
    main <= cyc[0];
    pll <= (cyc % 3) == 0;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    int k;
    bh = 1'b0;
    k = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!bh && k < 100) begin
      @(negedge clk);
      ah = awvalid && awready; wh = wvalid && wready; bh = bvalid && bready;
      resp = bresp;
      k++;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
    if (!bh) mismatches++;
  endtask

  task automatic rd_reg(input logic [6:0] a, output logic [31:0] d);
    logic ah, rh;
    int k;
    rh = 1'b0;
    k = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!rh && k < 100) begin
      @(negedge clk);
      ah = arvalid && arready; rh = rvalid && rready;
      d = rdata; resp = rresp;
      k++;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
    if (!rh) mismatches++;
  endtask

  // Cycles between two pulses of one programmable output
  task automatic gap(input int i, output int c);
    int k;
    k = 0;
    do begin @(negedge clk); k++; end while (prog[i] !== 1'b1 && k < 2000);
    c = 0;
    do begin @(negedge clk); c++; end while (prog[i] !== 1'b1 && c < 2000);
  endtask

  initial begin
    repeat (25000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    rst_adr = '{7'h08, 7'h18, 7'h68, 7'h2C, 7'h40, 7'h6C};
    exp_rd = '{32'h01, 32'h0, 32'h08, 32'h3F00, 32'h0, 32'h0};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values: status 0x01, gates off, slow source divide by 1
    for (int i = 0; i < 6; i++) begin
      rd_reg(rst_adr[i], rd);
      chk(rd, exp_rd[i]);
    end
    rd_reg(7'h0C, rd);
    chk({30'h0, resp}, 32'h2);
    wr(7'h60, 32'h0000_0700);
    rd_reg(7'h6C, rd);
    chk(rd, 32'h0000_0700);
    chk({31'h0, irq}, 32'h0);
    // Out 0 main /4, out 1 PLL /2, out 2 slow /64
    for (int i = 0; i < 3; i++) begin
      wr(7'h40 + 7'(4 * i), (i == 0) ? 32'h09 : (i == 1) ? 32'h07 : 32'h18);
      rd_reg(7'h40 + 7'(4 * i), rd);
      chk(rd, (i == 0) ? 32'h09 : (i == 1) ? 32'h07 : 32'h18);
      wr(7'h00, 32'h100 << i);
      rd_reg(7'h08, rd);
      chk(rd, 32'h01 | (32'h100 << i));
      gap(i, g);
      chk(32'(g), (i == 0) ? 32'd8 : (i == 1) ? 32'd6 : 32'd512);
      rd_reg(7'h68, rd);
      chk(rd, 32'h08 | (32'h100 << i));
      chk({31'h0, irq}, 32'h1);
      wr(7'h04, 32'h100 << i);
      rd_reg(7'h08, rd);
      chk(rd, 32'h01);
      chk({31'h0, irq}, 32'h0);
      gap(i, g);
      chk(32'(g), 32'd2000);
    end
    wr(7'h64, 32'h0000_0700);
    rd_reg(7'h6C, rd);
    chk(rd, 32'h0);
    // USB clock: zero does nothing, one enables
    wr(7'h00, 32'h0);
    chk({31'h0, usb}, 32'h0);
    wr(7'h00, 32'h80);
    chk({31'h0, usb}, 32'h1);
    rd_reg(7'h08, rd);
    chk(rd, 32'h81);
    wr(7'h04, 32'h80);
    chk({31'h0, usb}, 32'h0);
    // Gates 4 and 8 on, then 4 off; bits 0 and 1 are absent
    wr(7'h10, 32'h113);
    rd_reg(7'h18, rd);
    chk(rd, 32'h110);
    wr(7'h14, 32'h10);
    rd_reg(7'h18, rd);
    chk(rd, 32'h100);
    n4 = 0;
    n8 = 0;
    g = 0;
    repeat (40) begin
      @(negedge clk);
      n4 += int'(per_tick[4] === 1'b1);
      n8 += int'(per_tick[8] === 1'b1);
      g += int'(proc === 1'b1);
    end
    chk(32'(n4), 32'd0);
    chk(32'(n8), 32'd5);
    chk(32'(g), 32'd5);
    // Master: slow to PLL, PLL to main, then main divided by 64
    wr(7'h30, 32'h03);
    rd_reg(7'h68, rd);
    chk(rd, 32'h0);
    repeat (60) @(posedge clk);
    // PLL to main bound: 3 PLL + 4 slow + 1 main = 43 cycles
    wr(7'h30, 32'h01);
    repeat (45) @(posedge clk);
    rd_reg(7'h68, rd);
    chk(rd, 32'h08);
    // Prescaler adds up to 64 main periods (128 cycles) to the switch
    wr(7'h30, 32'h19);
    repeat (170) @(posedge clk);
    rd_reg(7'h68, rd);
    chk(rd, 32'h08);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
